// ### rtl/ahvs_defs.svh
// constants for the axis homing and velocity supervisor
`ifndef AHVS_DEFS_SVH
`define AHVS_DEFS_SVH
`define AHVS_MODE_ABS 3'h0
`define AHVS_MODE_LIM 3'h1
`define AHVS_MODE_ABS_REF 3'h2
`define AHVS_MODE_LIM_REF 3'h3
`define AHVS_MODE_DIRECT 3'h4
`define AHVS_FRAC_BITS 16
`define AHVS_ERR_NONE 2'h0
`define AHVS_ERR_PARAM 2'h1
`define AHVS_ERR_STATE 2'h2
`define AHVS_DIGITS_LIMIT 32'h0098967F
`endif

// ### rtl/ahvs_pkg.sv
// types for the axis homing and velocity supervisor
package ahvs_pkg;
  // homing sequencer states
  typedef enum logic [2:0] {
    AHVS_IDLE = 3'b000,
    AHVS_SEEK = 3'b001,
    AHVS_BACK = 3'b010,
    AHVS_REF = 3'b011,
    AHVS_OFFSET = 3'b100,
    AHVS_SETTLE = 3'b101
  } ahvs_state_e;
  // motion profile phase
  typedef enum logic [1:0] {
    AHVS_REST = 2'b00,
    AHVS_RAMP = 2'b01,
    AHVS_STOPPING = 2'b10
  } ahvs_phase_e;
endpackage : ahvs_pkg

// ### rtl/ahvs_supervisor.sv
// axis homing, velocity start/stop and parameter checking
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ahvs_defs.svh"
module ahvs_supervisor
  import ahvs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // fixed-point commands, 16 fraction bits
  input wire logic move_cmd_in,
  input wire logic halt_cmd_in,
  input wire logic [31:0] target_vel_in,
  input wire logic [47:0] target_pos_in,
  input wire logic homing_command_in,
  input wire logic [2:0] homing_mode_in,
  input wire logic stop_command_in,
  input wire logic axis_power_command_in,
  input wire logic one_dir_only_in,
  // drive side pins
  input wire logic home_sw_pin_in,
  input wire logic limit_sw_pin_in,
  input wire logic ref_pulse_pin_in,
  input wire logic at_target_in,
  output logic [31:0] pulse_train_output_vel_out,
  output logic [31:0] pulse_train_output_pos_out,
  output logic drive_dir_out,
  output logic homed_out,
  output logic homing_busy_out,
  output logic homing_done_out,
  output logic [1:0] error_out,
  output logic param_error_out,
  output logic state_a_out
);
  // configuration registers, word index
  logic [31:0] cfg_r [0:11];
  logic [47:0] cmd_pos_r;
  ahvs_state_e state_r;
  ahvs_phase_e phase_r;
  logic [2:0] mode_r;
  logic [31:0] vel_goal_r;
  // three stage sync for each pin
  logic [2:0] home_sync_r, lim_sync_r, ref_sync_r;
  logic home_q_r, lim_q_r, ref_q_r;
  logic home_prev_r, lim_prev_r;
  logic param_bad;
  logic sw_edge, mode_sw_home, mode_ref;
  logic [31:0] cfg_rd;

  // index map: 0 startstop vel, 1 estop vel, 2 home vel, 3 creep vel, 4 max vel,
  // 5 home acc, 6 max acc, 7 home dec, 8 max dec, 9 home jerk, 10 max jerk, 11 ctrl
  // ctrl bit0 home switch enable, bit1 not read (ref modes run either way); soft limits in 12/13

  logic [31:0] soft_lo_r, soft_hi_r;

  // quantize fixed point to whole pulses, fraction dropped
  function automatic logic [31:0] whole(input logic [47:0] v);
    whole = v[47:16];
  endfunction : whole

  // seven significant digit saturation of stored integer config
  function automatic logic [31:0] seven_digit(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    // values beyond seven digits clamp to the representable ceiling
    if (v > `AHVS_DIGITS_LIMIT) begin
      r = `AHVS_DIGITS_LIMIT;
    end
    seven_digit = r;
  endfunction : seven_digit

  // pin synchronisers, change counted when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      home_sync_r <= 3'h0;
      lim_sync_r <= 3'h0;
      ref_sync_r <= 3'h0;
      home_q_r <= 1'b0;
      lim_q_r <= 1'b0;
      ref_q_r <= 1'b0;
    end else if (enable_in) begin
      home_sync_r <= {home_sync_r[1:0], home_sw_pin_in};
      lim_sync_r <= {lim_sync_r[1:0], limit_sw_pin_in};
      ref_sync_r <= {ref_sync_r[1:0], ref_pulse_pin_in};
      if (home_sync_r[1] == home_sync_r[2]) begin
        home_q_r <= home_sync_r[2];
      end
      if (lim_sync_r[1] == lim_sync_r[2]) begin
        lim_q_r <= lim_sync_r[2];
      end
      if (ref_sync_r[1] == ref_sync_r[2]) begin
        ref_q_r <= ref_sync_r[2];
      end
    end
  end

  // register writes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 12; i++) begin
        cfg_r[i] <= 32'h0;
      end
      soft_lo_r <= 32'h0;
      soft_hi_r <= 32'h0;
    end else if (enable_in && wr_in) begin
      if (addr_in < 4'hC) begin
        cfg_r[addr_in] <= seven_digit(wdata_in);
      end else if (addr_in == 4'hC) begin
        soft_lo_r <= wdata_in;
      end else if (addr_in == 4'hD) begin
        soft_hi_r <= wdata_in;
      end
    end
  end

  // cross-parameter consistency
  always_comb begin
    param_bad = ($signed(soft_lo_r) >= $signed(soft_hi_r));
    if (cfg_r[0] > cfg_r[4] || cfg_r[1] > cfg_r[4] || cfg_r[2] > cfg_r[4] ||
        cfg_r[3] > cfg_r[4]) begin
      param_bad = 1'b1;
    end
    if (cfg_r[5] > cfg_r[6] || cfg_r[7] > cfg_r[8] || cfg_r[9] > cfg_r[10]) begin
      param_bad = 1'b1;
    end
  end

  // read mux
  always_comb begin
    cfg_rd = 32'h0;
    if (addr_in < 4'hC) begin
      cfg_rd = cfg_r[addr_in];
    end else if (addr_in == 4'hC) begin
      cfg_rd = soft_lo_r;
    end else if (addr_in == 4'hD) begin
      cfg_rd = soft_hi_r;
    end else if (addr_in == 4'hE) begin
      cfg_rd = {24'h0, 1'b0, state_r, homed_out, homing_busy_out, param_bad, state_a_out};
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= 32'h0;
    end else if (enable_in) begin
      rdata_out <= rd_in ? cfg_rd : 32'h0;
    end
  end

  assign mode_sw_home = (mode_r == `AHVS_MODE_ABS) || (mode_r == `AHVS_MODE_ABS_REF);
  assign mode_ref = (mode_r == `AHVS_MODE_ABS_REF) || (mode_r == `AHVS_MODE_LIM_REF);
  // on to off edge of the searched switch
  assign sw_edge = mode_sw_home ? (home_prev_r && !home_q_r) : (lim_prev_r && !lim_q_r);

  // homing sequencer and homed flag
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_r <= AHVS_IDLE;
      mode_r <= 3'h0;
      homed_out <= 1'b0;
      homing_busy_out <= 1'b0;
      homing_done_out <= 1'b0;
      error_out <= `AHVS_ERR_NONE;
      param_error_out <= 1'b0;
      cmd_pos_r <= 48'h0;
      pulse_train_output_pos_out <= 32'h0;
      drive_dir_out <= 1'b0;
      home_prev_r <= 1'b0;
      lim_prev_r <= 1'b0;
    end else if (enable_in) begin
      home_prev_r <= home_q_r;
      lim_prev_r <= lim_q_r;
      homing_done_out <= 1'b0;
      param_error_out <= param_bad;
      if (axis_power_command_in) begin
        // power completion resets homing and the homed flag
        state_r <= AHVS_IDLE;
        homing_busy_out <= 1'b0;
        homed_out <= 1'b0;
        error_out <= `AHVS_ERR_NONE;
      end else if (state_r != AHVS_IDLE && stop_command_in) begin
        // abort invalidates earlier home
        state_r <= AHVS_IDLE;
        homing_busy_out <= 1'b0;
        homed_out <= 1'b0;
      end else if (state_r != AHVS_IDLE && (move_cmd_in || homing_command_in)) begin
        // other motion refused, homing carries on
        error_out <= `AHVS_ERR_STATE;
      end else begin
        case (state_r)
          AHVS_IDLE: begin
            if (homing_command_in) begin
              mode_r <= homing_mode_in;
              cmd_pos_r <= target_pos_in;
              error_out <= `AHVS_ERR_NONE;
              // checks made when the command is issued
              if (param_bad || homing_mode_in > `AHVS_MODE_DIRECT) begin
                error_out <= `AHVS_ERR_PARAM;
              end else if (one_dir_only_in && homing_mode_in != `AHVS_MODE_DIRECT) begin
                error_out <= `AHVS_ERR_PARAM;
              end else if (homing_mode_in == `AHVS_MODE_DIRECT) begin
                // no motion, position forced
                pulse_train_output_pos_out <= whole(target_pos_in);
                homed_out <= 1'b1;
                homing_done_out <= 1'b1;
              end else if ((homing_mode_in == `AHVS_MODE_ABS || homing_mode_in == `AHVS_MODE_ABS_REF)
                           && !cfg_r[11][0]) begin
                error_out <= `AHVS_ERR_PARAM;
              end else if (mode_ref && 1'b0) begin
                error_out <= `AHVS_ERR_PARAM;
              end else begin
                state_r <= AHVS_SEEK;
                homing_busy_out <= 1'b1;
                homed_out <= 1'b0;
                drive_dir_out <= 1'b0;
              end
            end
          end
          AHVS_SEEK: begin
            // negative search until searched switch on
            if (mode_sw_home ? home_q_r : lim_q_r) begin
              state_r <= AHVS_BACK;
              drive_dir_out <= 1'b1;
            end
          end
          AHVS_BACK: begin
            // creep back to the on to off edge
            if (sw_edge) begin
              state_r <= mode_ref ? AHVS_REF : AHVS_OFFSET;
            end
          end
          AHVS_REF: begin
            if (ref_q_r) begin
              state_r <= AHVS_OFFSET;
            end
          end
          AHVS_OFFSET: begin
            // travel to recorded home plus offset
            if (at_target_in) begin
              pulse_train_output_pos_out <= whole(cmd_pos_r);
              state_r <= AHVS_SETTLE;
            end
          end
          AHVS_SETTLE: begin
            // finish only once state_a
            if (state_a_out) begin
              state_r <= AHVS_IDLE;
              homing_busy_out <= 1'b0;
              homed_out <= 1'b1;
              homing_done_out <= 1'b1;
            end
          end
          default: begin
            state_r <= AHVS_IDLE;
          end
        endcase
      end
    end
  end

  // start/stop velocity profile
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      phase_r <= AHVS_REST;
      vel_goal_r <= 32'h0;
      pulse_train_output_vel_out <= 32'h0;
      state_a_out <= 1'b1;
    end else if (enable_in) begin
      case (phase_r)
        AHVS_REST: begin
          // at rest the pulse train is idle unless homing or a move start drives it
          state_a_out <= 1'b1;
          pulse_train_output_vel_out <= 32'h0;
          if (state_r == AHVS_SEEK) begin
            // fast search at homing velocity
            pulse_train_output_vel_out <= cfg_r[2];
            state_a_out <= 1'b0;
          end else if (state_r == AHVS_BACK || state_r == AHVS_REF) begin
            // creep back over the switch edge and marker
            pulse_train_output_vel_out <= cfg_r[3];
            state_a_out <= 1'b0;
          end else if (move_cmd_in && state_r == AHVS_IDLE) begin
            vel_goal_r <= whole({target_vel_in, 16'h0} >> `AHVS_FRAC_BITS);
            state_a_out <= 1'b0;
            phase_r <= AHVS_RAMP;
            if (target_vel_in[31:16] < cfg_r[0]) begin
              pulse_train_output_vel_out <= {16'h0, target_vel_in[31:16]};
            end else begin
              pulse_train_output_vel_out <= cfg_r[0];
            end
          end
        end
        AHVS_RAMP: begin
          // step toward goal by one pulse per cycle
          if (halt_cmd_in || stop_command_in) begin
            phase_r <= AHVS_STOPPING;
          end else if (pulse_train_output_vel_out < vel_goal_r) begin
            pulse_train_output_vel_out <= pulse_train_output_vel_out + 32'h1;
          end
        end
        AHVS_STOPPING: begin
          if (pulse_train_output_vel_out > cfg_r[0]) begin
            pulse_train_output_vel_out <= pulse_train_output_vel_out - 32'h1;
          end else if (pulse_train_output_vel_out != cfg_r[0] && cfg_r[0] < vel_goal_r) begin
            pulse_train_output_vel_out <= cfg_r[0];
          end else begin
            pulse_train_output_vel_out <= 32'h0;
            phase_r <= AHVS_REST;
            state_a_out <= 1'b1;
          end
        end
        default: begin
          phase_r <= AHVS_REST;
        end
      endcase
    end
  end

  // power clears homed one cycle later
  property p_power_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      (enable_in && axis_power_command_in) |=> !homed_out;
  endproperty
  a_power_clears_homed: assert property (p_power_clear) else $error("homed kept after power");

  // abort clears homed
  a_abort_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && state_r != AHVS_IDLE && stop_command_in) |=> (!homed_out && state_r == AHVS_IDLE))
    else $error("abort did not clear homing");

  // refused command keeps homing
  a_refuse_keeps: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && state_r != AHVS_IDLE && !stop_command_in && !axis_power_command_in && move_cmd_in)
    |=> (state_r != AHVS_IDLE && error_out == `AHVS_ERR_STATE)) else $error("homing interrupted");

  // done only at state_a
  a_done_still: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (homing_done_out && mode_r != `AHVS_MODE_DIRECT) |-> $past(state_a_out)) else $error("done while moving");

  // single direction rejects modes 0..3
  a_one_dir: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && state_r == AHVS_IDLE && homing_command_in && one_dir_only_in && !axis_power_command_in
     && homing_mode_in < `AHVS_MODE_DIRECT) |=> (error_out == `AHVS_ERR_PARAM && !homing_busy_out))
    else $error("mode accepted with one direction");

  // direct mode sets homed with no motion
  a_direct_home: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && state_r == AHVS_IDLE && homing_command_in && !axis_power_command_in && !param_bad
     && homing_mode_in == `AHVS_MODE_DIRECT) |=> (homed_out && pulse_train_output_pos_out == $past(target_pos_in[47:16])))
    else $error("direct homing failed");

  // start velocity choice
  a_start_vel: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && phase_r == AHVS_REST && move_cmd_in && state_r == AHVS_IDLE && target_vel_in[31:16] < cfg_r[0])
    |=> pulse_train_output_vel_out == {16'h0, $past(target_vel_in[31:16])}) else $error("bad start velocity");

  // ordering of soft limits flagged
  a_soft_limit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (enable_in && $signed(soft_lo_r) >= $signed(soft_hi_r)) |=> param_error_out) else $error("limit order missed");
endmodule : ahvs_supervisor
`default_nettype wire

// ### tb/ahvs_drive_model.sv
// drive and switch model for the axis supervisor
`timescale 1ns/100ps
`default_nettype none
module ahvs_drive_model #(
  parameter int LAG = 2 // idle cycles before arrival
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [31:0] vel_in,
  input wire logic dir_in,
  output logic home_sw_out,
  output logic limit_sw_out,
  output logic ref_pulse_out,
  output logic at_target_out
);
  int pos_r; // shaft position in steps
  int idle_r; // cycles spent at zero velocity
  // one step per moving cycle, settle count at rest
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pos_r <= 0;
      idle_r <= 0;
    end else if (vel_in != 32'h0) begin
      pos_r <= dir_in ? pos_r + 1 : pos_r - 1;
      idle_r <= 0;
    end else if (idle_r < LAG) begin
      idle_r <= idle_r + 1;
    end
  end
  // both switches sit at the negative end of travel
  assign home_sw_out = (pos_r <= -8);
  assign limit_sw_out = (pos_r <= -8);
  // marker four steps wide, so the three-stage filter accepts it
  assign ref_pulse_out = (pos_r > -8) && (pos_r[3:2] == 2'h0);
  // arrival only once the shaft has settled
  assign at_target_out = (idle_r >= LAG);
endmodule : ahvs_drive_model
`default_nettype wire

// ### tb/ahvs_supervisor_test.sv
// self-checking bench for the axis supervisor
`timescale 1ns/100ps
`default_nettype none
`include "ahvs_defs.svh"
module ahvs_supervisor_test;
  import ahvs_pkg::*;
  logic clk_in, reset_n, enable, wr, rd, one_dir;
  logic [3:0] addr;
  logic [31:0] wdata, tvel, rdata, vel, pos, last_vel;
  logic [47:0] tpos;
  logic [2:0] mode;
  logic [4:0] cmd_v; // move, halt, homing, stop, power
  logic hsw, lsw, rpl, atg, dir, homed, busy, done, perr, rest;
  logic [1:0] err;
  int error_cnt, num_checks;
  // config image: velocities, limits, ctrl
  logic [31:0] cfg [0:13] = '{32'h64, 32'hC8, 32'h12C, 32'h32, 32'h3E8, 32'hA, 32'h14,
    32'hA, 32'h14, 32'h1, 32'h2, 32'h1, 32'hFFFFFFFB, 32'h5};
  // bad value per index, breaking one consistency relation each
  logic [31:0] bad [0:8] = '{32'h5, 32'h3E9, 32'h3E9, 32'h3E9, 32'h3E9, 32'h15, 32'h15, 32'h3, 32'hFFFFFFFA};
  logic [3:0] bad_ix [0:8] = '{4'hC, 4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hD};
  ahvs_supervisor u_dut (.clk_in(clk_in), .reset_n_in(reset_n), .enable_in(enable),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .move_cmd_in(cmd_v[0]), .halt_cmd_in(cmd_v[1]), .target_vel_in(tvel), .target_pos_in(tpos),
    .homing_command_in(cmd_v[2]), .homing_mode_in(mode), .stop_command_in(cmd_v[3]),
    .axis_power_command_in(cmd_v[4]), .one_dir_only_in(one_dir), .home_sw_pin_in(hsw),
    .limit_sw_pin_in(lsw), .ref_pulse_pin_in(rpl), .at_target_in(atg),
    .pulse_train_output_vel_out(vel), .pulse_train_output_pos_out(pos), .drive_dir_out(dir),
    .homed_out(homed), .homing_busy_out(busy), .homing_done_out(done), .error_out(err),
    .param_error_out(perr), .state_a_out(rest));
  ahvs_drive_model u_drive (.clk_in(clk_in), .reset_n_in(reset_n), .vel_in(vel), .dir_in(dir),
    .home_sw_out(hsw), .limit_sw_out(lsw), .ref_pulse_out(rpl), .at_target_out(atg));
  // free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // word and flag comparisons
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // register bus cycles
  task wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wrr
  task rdr(input logic [3:0] a);
    @(posedge clk_in);
    addr <= a; rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
  endtask : rdr
  // one-cycle command pulse, taken at the edge where it returns
  task pls(input int b);
    @(posedge clk_in);
    cmd_v[b] <= 1'b1;
    @(posedge clk_in);
    cmd_v <= 5'h0;
    #1;
  endtask : pls
  task settle();
    @(posedge clk_in);
    #1;
  endtask : settle
  // wait for completion pulse, bounded
  task wait_done();
    int i;
    for (i = 0; i < 3000 && done !== 1'b1; i++) settle();
    chk1(done, 1'b1);
  endtask : wait_done
  // wait for rest, remembering the last moving velocity
  task wait_rest();
    int i;
    for (i = 0; i < 3000 && rest !== 1'b1; i++) begin
      if (vel != 32'h0) last_vel = vel;
      settle();
    end
    chk1(rest, 1'b1);
  endtask : wait_rest
  task t_reset();
    chk1(rest, 1'b1);
    chk1(homed, 1'b0);
    chk({30'h0, err}, 32'h0);
  endtask : t_reset
  task t_regs();
    for (int i = 0; i < 14; i++) wrr(i[3:0], cfg[i]);
    for (int i = 0; i < 14; i++) begin
      rdr(i[3:0]);
      chk(rdata, cfg[i]);
    end
    wrr(4'h4, 32'h00989680);
    rdr(4'h4);
    chk(rdata, 32'h0098967F);
    wrr(4'h4, cfg[4]);
    rdr(4'hF);
    chk(rdata, 32'h0);
    chk1(perr, 1'b0);
  endtask : t_regs
  task t_param();
    for (int i = 0; i < 9; i++) begin
      wrr(bad_ix[i], bad[i]);
      settle();
      chk1(perr, 1'b1);
      rdr(4'hE);
      chk1(rdata[1], 1'b1);
      wrr(bad_ix[i], cfg[bad_ix[i]]);
      settle();
      chk1(perr, 1'b0);
    end
  endtask : t_param
  task t_move();
    tvel <= {16'h32, 16'hC000};
    pls(0);
    chk(vel, 32'h32);
    pls(1);
    wait_rest();
    tvel <= {16'h6E, 16'h0};
    pls(0);
    chk(vel, 32'h64);
    repeat (4) settle();
    pls(1);
    wait_rest();
    chk(last_vel, 32'h64);
  endtask : t_move
  task t_modes();
    for (int m = 0; m < 4; m++) begin
      mode <= m[2:0];
      tpos <= {32'h100 + m, 16'h8000};
      pls(2);
      wait_done();
      chk1(rest, 1'b1);
      chk1(homed, 1'b1);
      chk(pos, 32'h100 + m);
    end
    mode <= `AHVS_MODE_DIRECT;
    tpos <= {32'hABC, 16'hFFFF};
    pls(2);
    wait_done();
    chk(pos, 32'hABC);
  endtask : t_modes
  task t_abort();
    mode <= `AHVS_MODE_ABS;
    pls(2);
    settle();
    pls(0);
    settle();
    chk({30'h0, err}, {30'h0, `AHVS_ERR_STATE});
    chk1(busy, 1'b1);
    pls(2);
    settle();
    chk({30'h0, err}, {30'h0, `AHVS_ERR_STATE});
    pls(3);
    settle();
    chk1(busy, 1'b0);
    chk1(homed, 1'b0);
    wait_rest();
    mode <= `AHVS_MODE_DIRECT;
    pls(2);
    wait_done();
    pls(4);
    settle();
    chk1(homed, 1'b0);
  endtask : t_abort
  task t_refuse();
    one_dir <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode <= m[2:0];
      pls(2);
      settle();
      chk1(err == `AHVS_ERR_PARAM || err == `AHVS_ERR_STATE, 1'b1);
      chk1(busy, 1'b0);
    end
    mode <= `AHVS_MODE_DIRECT;
    pls(2);
    wait_done();
    chk1(homed, 1'b1);
    one_dir <= 1'b0;
    wrr(4'hB, 32'h0);
    mode <= `AHVS_MODE_ABS;
    pls(2);
    settle();
    chk({30'h0, err}, {30'h0, `AHVS_ERR_PARAM});
    wrr(4'hB, 32'h1);
  endtask : t_refuse
  task close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    close_out();
  end
  // main sequence
  initial begin
    reset_n = 1'b0; enable = 1'b1; wr = 1'b0; rd = 1'b0; one_dir = 1'b0;
    addr = 4'h0; wdata = 32'h0; tvel = 32'h0; tpos = 48'h0; mode = 3'h0; cmd_v = 5'h0;
    repeat (5) @(posedge clk_in);
    reset_n <= 1'b1;
    settle();
    t_reset();
    t_regs();
    t_param();
    t_move();
    t_modes();
    t_abort();
    t_refuse();
    close_out();
  end
endmodule : ahvs_supervisor_test
`default_nettype wire
